// ==== core/move_bit_exec.sv ====
// Execution unit for the move, bit and branch group of a nibble core.
// Assumes an APB master on pclk; one instruction runs per accepted APB write to REG_INSTR.
`timescale 1ns/1ps
`include "move_bit_params.svh"

module move_bit_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire move_bit_pkg::apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic branch_condition_flag,
    output logic [`PC_W-1:0] instruction_pointer,
    output logic [`NIB_W-1:0] active_rom_bank
);
    import move_bit_pkg::*;

    exec_state_t state_ff;
    exec_state_t nxt_state;
    logic [`PC_W-1:0] pc_step;
    logic setup;
    logic done;
    logic exec_go;
    opcode_t op_now;
    logic [`ARG_ADDR_MSB:0] arg;
    logic [5:0] idx;
    logic [`NIB_W-1:0] cur_nib;

    // RAM word address from page and word index
    function automatic logic [5:0] ram_index(
        input logic [`NIB_W-1:0] px,
        input logic [`NIB_W-1:0] wy
    );
        ram_index = {px[`ARG_PAGE_MSB:0], wy};
    endfunction : ram_index

    // One-hot mask of the operand-selected bit
    function automatic logic [`NIB_W-1:0] bit_mask(
        input logic [`ARG_BIT_MSB:0] n
    );
        bit_mask = 4'h1 << n;
    endfunction : bit_mask

    // Legal instruction codes
    function automatic logic op_legal(input logic [3:0] code);
        op_legal = code <= 4'(load_bank_buffer_const);
    endfunction : op_legal

    // Address decode for the error answer; the read mux decodes on its own
    function automatic logic addr_known(input logic [`ADDR_W-1:0] a);
        addr_known = (a == `REG_INSTR) || (a == `REG_WORK) ||
            (a == `REG_INDEX) || (a == `REG_FLAG) ||
            (a == `REG_IPTR) || (a == `REG_BANK) || (a == `REG_MEM);
    endfunction : addr_known

    // Readback; unmapped addresses and reserved bits read zero
    function automatic logic [31:0] read_word(
        input exec_state_t s,
        input logic [`ADDR_W-1:0] a
    );
        read_word = `RST_WORD;
        case (a)
            `REG_WORK: read_word[`NIB_W-1:0] = s.work;
            `REG_INDEX: begin
                read_word[`NIB_W-1:0] = s.y;
                read_word[`IDX_X_MSB:`IDX_X_LSB] = s.x;
            end
            `REG_FLAG: begin
                read_word[`FLAG_COND_BIT] = s.cond;
                read_word[`FLAG_TAKEN_BIT] = s.taken;
                read_word[`FLAG_LONG_BIT] = s.long_jump;
            end
            `REG_IPTR: read_word[`PC_W-1:0] = s.pc;
            `REG_BANK: begin
                read_word[`NIB_W-1:0] = s.pa;
                read_word[`BANK_PB_MSB:`BANK_PB_LSB] = s.pb;
            end
            `REG_MEM: read_word[`NIB_W-1:0] = s.ram[ram_index(s.x, s.y)];
            default: read_word = `RST_WORD;
        endcase
    endfunction : read_word

    pc_sequencer seq_u (
        .cur(state_ff.pc),
        .nxt(pc_step)
    );

    // Bus phases; the slave answers in the first access cycle
    assign setup = apb_req.psel && !apb_req.penable;
    assign done = apb_req.psel && apb_req.penable && state_ff.pready;
    assign op_now = opcode_t'(apb_req.pwdata[`OP_MSB:`OP_LSB]);
    assign arg = apb_req.pwdata[`ARG_ADDR_MSB:0];
    assign exec_go = done && apb_req.pwrite && !state_ff.pslverr &&
        (apb_req.paddr == `REG_INSTR);
    assign idx = ram_index(state_ff.x, state_ff.y);
    assign cur_nib = state_ff.ram[idx];

    // Next state: bus answer, direct register writes, instruction execution
    always_comb begin
        nxt_state = state_ff;
        if (setup) begin
            nxt_state.pready = 1'b1;
            nxt_state.prdata = read_word(state_ff, apb_req.paddr);
            // Bad codes are refused so software sees them
            nxt_state.pslverr = !addr_known(apb_req.paddr) ||
                (apb_req.pwrite && apb_req.paddr == `REG_INSTR &&
                !op_legal(apb_req.pwdata[`OP_MSB:`OP_LSB]));
        end
        if (done) begin
            nxt_state.pready = 1'b0;
            nxt_state.pslverr = 1'b0;
        end
        if (done && apb_req.pwrite && !state_ff.pslverr) begin
            case (apb_req.paddr)
                `REG_WORK: nxt_state.work = apb_req.pwdata[`NIB_W-1:0];
                `REG_INDEX: begin
                    nxt_state.y = apb_req.pwdata[`NIB_W-1:0];
                    nxt_state.x = apb_req.pwdata[`IDX_X_MSB:`IDX_X_LSB];
                end
                `REG_FLAG: nxt_state.cond = apb_req.pwdata[`FLAG_COND_BIT];
                `REG_IPTR: nxt_state.pc = apb_req.pwdata[`PC_W-1:0];
                `REG_BANK: begin
                    nxt_state.pa = apb_req.pwdata[`NIB_W-1:0];
                    nxt_state.pb = apb_req.pwdata[`BANK_PB_MSB:`BANK_PB_LSB];
                end
                `REG_MEM: nxt_state.ram[idx] = apb_req.pwdata[`NIB_W-1:0];
                default: nxt_state.pc = state_ff.pc;
            endcase
        end
        if (exec_go) begin
            // Sequential step unless a jump is taken
            nxt_state.pc = pc_step;
            nxt_state.cond = 1'b1;
            unique case (op_now)
                store_work_and_step_index: begin
                    nxt_state.ram[idx] = state_ff.work;
                    nxt_state.y = 4'(state_ff.y + 4'h1);
                end
                load_index_from_ram: nxt_state.y = cur_nib;
                load_work_from_ram: nxt_state.work = cur_nib;
                swap_work_with_ram: begin
                    nxt_state.work = cur_nib;
                    nxt_state.ram[idx] = state_ff.work;
                end
                store_const_and_step_index: begin
                    nxt_state.ram[idx] = arg[`ARG_NIB_MSB:0];
                    nxt_state.y = 4'(state_ff.y + 4'h1);
                end
                load_bank_select_const: begin
                    // Upper bits zero: only four pages exist
                    nxt_state.x = {2'b00, arg[`ARG_PAGE_MSB:0]};
                end
                set_ram_bit: begin
                    nxt_state.ram[idx] =
                        cur_nib | bit_mask(arg[`ARG_BIT_MSB:0]);
                end
                clear_ram_bit: begin
                    nxt_state.ram[idx] =
                        cur_nib & ~bit_mask(arg[`ARG_BIT_MSB:0]);
                end
                test_ram_bit: begin
                    nxt_state.cond =
                        |(cur_nib & bit_mask(arg[`ARG_BIT_MSB:0]));
                end
                conditional_jump: begin
                    nxt_state.taken = state_ff.cond;
                    if (state_ff.cond) begin
                        nxt_state.pa = state_ff.pb;
                        nxt_state.pc = arg;
                        // Long only when the buffer names another page
                        nxt_state.long_jump =
                            state_ff.pb != state_ff.pa;
                    end else begin
                        nxt_state.long_jump = 1'b0;
                    end
                end
                load_bank_buffer_const: begin
                    nxt_state.pb = arg[`ARG_NIB_MSB:0];
                end
                default: nxt_state.pc = pc_step;
            endcase
        end
    end

    // Single state register; reset clears RAM and all else except the flag, which loads 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
            state_ff.cond <= `RST_FLAG;
            state_ff.pc <= `RST_PC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign branch_condition_flag = state_ff.cond;
    assign instruction_pointer = state_ff.pc;
    assign active_rom_bank = state_ff.pa;

    // Execution of a given code in this cycle
    sequence run_s(opcode_t code);
        exec_go && op_now == code;
    endsequence

    sequence jump_flag_s(logic f);
        run_s(conditional_jump) ##0 state_ff.cond == f;
    endsequence

    bus_answer_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("APB answer not one access cycle");

    store_work_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(store_work_and_step_index) |=>
        state_ff.ram[ram_index($past(state_ff.x), $past(state_ff.y))] ==
        $past(state_ff.work) && state_ff.work == $past(state_ff.work) &&
        state_ff.y == 4'($past(state_ff.y) + 4'h1))
        else $error("store work and step wrong");

    load_index_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(load_index_from_ram) |=>
        state_ff.y == $past(cur_nib) && state_ff.ram == $past(state_ff.ram))
        else $error("index load from RAM wrong");

    load_work_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(load_work_from_ram) |=>
        state_ff.work == $past(cur_nib) && state_ff.ram == $past(state_ff.ram))
        else $error("work load from RAM wrong");

    swap_pair_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(swap_work_with_ram) |=>
        state_ff.work == $past(cur_nib) &&
        state_ff.ram[$past(idx)] == $past(state_ff.work))
        else $error("swap did not exchange");

    store_const_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(store_const_and_step_index) |=>
        state_ff.ram[$past(idx)] == $past(arg[`ARG_NIB_MSB:0]) &&
        state_ff.y == 4'($past(state_ff.y) + 4'h1))
        else $error("store constant wrong");

    page_select_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(load_bank_select_const) |=>
        state_ff.x == {2'b00, $past(arg[`ARG_PAGE_MSB:0])})
        else $error("page index load wrong");

    bit_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(set_ram_bit) |=>
        state_ff.ram[$past(idx)] ==
        ($past(cur_nib) | bit_mask($past(arg[`ARG_BIT_MSB:0]))))
        else $error("bit set wrong");

    bit_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(clear_ram_bit) |=>
        state_ff.ram[$past(idx)] ==
        ($past(cur_nib) & ~bit_mask($past(arg[`ARG_BIT_MSB:0]))))
        else $error("bit clear wrong");

    bit_test_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_s(test_ram_bit) |=>
        branch_condition_flag ==
        $past(cur_nib[arg[`ARG_BIT_MSB:0]]) && $stable(state_ff.ram))
        else $error("bit test flag wrong");

    flag_force_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        exec_go && op_now != test_ram_bit |=> branch_condition_flag)
        else $error("flag not set after instruction");

    jump_taken_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        jump_flag_s(1'b1) |=> instruction_pointer == $past(arg) &&
        active_rom_bank == $past(state_ff.pb))
        else $error("taken jump wrong");

    jump_skip_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        jump_flag_s(1'b0) |=> instruction_pointer == $past(pc_step) &&
        branch_condition_flag && $stable(active_rom_bank))
        else $error("untaken jump wrong");

    seq_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        exec_go && op_now != conditional_jump |=>
        instruction_pointer == $past(pc_step))
        else $error("counter did not follow sequence");

    jump_kind_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        jump_flag_s(1'b1) |=>
        state_ff.long_jump == ($past(state_ff.pb) != $past(state_ff.pa)))
        else $error("short or long jump misjudged");

    index_wrap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        exec_go && state_ff.y == 4'hf &&
        (op_now == store_work_and_step_index ||
        op_now == store_const_and_step_index) |=>
        state_ff.y == 4'h0)
        else $error("word index did not wrap");

endmodule : move_bit_exec

// ==== core/move_bit_params.svh ====
// Constants for the move, bit and branch execution unit.
// Assumes inclusion by the package and the design files by bare name.
`ifndef MOVE_BIT_PARAMS_SVH
`define MOVE_BIT_PARAMS_SVH

// Register byte addresses on the APB slave
`define ADDR_W 8
`define REG_INSTR 8'h00
`define REG_WORK 8'h04
`define REG_INDEX 8'h08
`define REG_FLAG 8'h0c
`define REG_IPTR 8'h10
`define REG_BANK 8'h14
`define REG_MEM 8'h18

// Instruction word layout
`define OP_MSB 11
`define OP_LSB 8
`define ARG_NIB_MSB 3
`define ARG_BIT_MSB 1
`define ARG_PAGE_MSB 1
`define ARG_ADDR_MSB 5

// Readback field positions
`define IDX_X_LSB 4
`define IDX_X_MSB 7
`define BANK_PB_LSB 4
`define BANK_PB_MSB 7
`define FLAG_COND_BIT 0
`define FLAG_TAKEN_BIT 1
`define FLAG_LONG_BIT 2

// Sizes and reset values
`define NIB_W 4
`define PC_W 6
`define RAM_WORDS 64
`define RST_NIB 4'h0
`define RST_PC 6'h00
`define RST_FLAG 1'b1
`define RST_WORD 32'h0000_0000

// Sequencer lock-up escape
`define SEQ_LOCK 6'h3f
`define SEQ_RESTART 6'h00

`endif

// ==== core/move_bit_pkg.sv ====
// Types shared by the execution unit and its bus.
// Assumes the constants header sits beside this file.
`include "move_bit_params.svh"

package move_bit_pkg;

    // Instruction codes carried in the instruction word
    typedef enum logic [3:0] {
        store_work_and_step_index = 4'h0,
        load_index_from_ram = 4'h1,
        load_work_from_ram = 4'h2,
        swap_work_with_ram = 4'h3,
        store_const_and_step_index = 4'h4,
        load_bank_select_const = 4'h5,
        set_ram_bit = 4'h6,
        clear_ram_bit = 4'h7,
        test_ram_bit = 4'h8,
        conditional_jump = 4'h9,
        load_bank_buffer_const = 4'ha
    } opcode_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // Whole state of the execution unit
    typedef struct packed {
        logic [`NIB_W-1:0] work;
        logic [`NIB_W-1:0] x;
        logic [`NIB_W-1:0] y;
        logic cond;
        logic [`PC_W-1:0] pc;
        logic [`NIB_W-1:0] pa;
        logic [`NIB_W-1:0] pb;
        logic taken;
        logic long_jump;
        logic [`RAM_WORDS-1:0][`NIB_W-1:0] ram;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } exec_state_t;

endpackage : move_bit_pkg

// ==== core/pc_sequencer.sv ====
// Next-address logic of the pseudo-random program counter.
// Assumes a 6-bit counter; purely combinational, caller registers it.
`timescale 1ns/1ps
`include "move_bit_params.svh"

module pc_sequencer (
    input wire logic [`PC_W-1:0] cur,
    output logic [`PC_W-1:0] nxt
);
    import move_bit_pkg::*;

    // Shift with xnor feedback; the one stuck code is forced back in
    always_comb begin
        if (cur == `SEQ_LOCK) begin
            nxt = `SEQ_RESTART;
        end else begin
            nxt = {cur[`PC_W-2:0], ~(cur[`PC_W-1] ^ cur[`PC_W-2])};
        end
    end
endmodule : pc_sequencer

// ==== verification/tb.sv ====
// Self-checking bench for the move, bit and branch execution unit.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "move_bit_params.svh"

module tb;
    import move_bit_pkg::*;

    logic pclk;
    logic presetn;
    apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic flag;
    logic [`PC_W-1:0] iptr;
    logic [`NIB_W-1:0] bank;
    // Reference copy of the core state
    logic [3:0] m_work, m_x, m_y, m_pa, m_pb;
    logic m_flag;
    // Readback of the last jump: taken and long bits
    logic m_taken, m_long;
    logic [5:0] m_pc;
    logic [3:0] m_ram [64];
    logic [33:0] notes [$];
    logic [33:0] note;
    logic [31:0] rnd;
    int err_total, n_tests, cycles;

    move_bit_exec u_move_bit_exec (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .branch_condition_flag(flag),
        .instruction_pointer(iptr),
        .active_rom_bank(bank)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Hang guard, generous for the few thousand cycles needed
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            report_and_stop();
        end
    end

    // Monitor: each completed transfer takes the oldest note
    always @(posedge pclk) begin
        if (req.psel && req.penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                cmp(32'h0, 32'h1);
            end else begin
                note = notes.pop_front();
                cmp({31'h0, pslverr}, {31'h0, note[32]});
                if (!note[33]) begin
                    cmp(prdata, note[31:0]);
                end
            end
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    // Pseudo-random counter step, own copy for the expectations
    function automatic logic [5:0] seq(input logic [5:0] p);
        return (p == 6'h3f) ? 6'h00 : {p[4:0], ~(p[5] ^ p[4])};
    endfunction : seq

    // One APB transfer; the note records what the monitor must see
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic e,
                       input logic [31:0] exp);
        notes.push_back({w, e, exp});
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        // No wait count assumed; only the hang guard ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0, exp);
    endtask : rd

    task automatic set_index(input logic [3:0] x, input logic [3:0] y);
        m_x = x;
        m_y = y;
        wr(`REG_INDEX, {24'h0, x, y});
    endtask : set_index

    task automatic ports();
        @(negedge pclk);
        cmp({31'h0, flag}, {31'h0, m_flag});
        cmp({26'h0, iptr}, {26'h0, m_pc});
        cmp({28'h0, bank}, {28'h0, m_pa});
    endtask : ports

    task automatic check_regs();
        rd(`REG_WORK, {28'h0, m_work});
        rd(`REG_INDEX, {24'h0, m_x, m_y});
        rd(`REG_BANK, {24'h0, m_pb, m_pa});
        rd(`REG_MEM, {28'h0, m_ram[{m_x[1:0], m_y}]});
        rd(`REG_IPTR, {26'h0, m_pc});
        rd(`REG_FLAG, {29'h0, m_long, m_taken, m_flag});
    endtask : check_regs

    // Runs one instruction on both the model and the design
    task automatic exec(input logic [3:0] op, input logic [5:0] arg);
        logic [5:0] a;
        logic [3:0] t;
        logic taken;
        a = {m_x[1:0], m_y};
        taken = (op == 4'h9) && m_flag;
        case (op)
            4'h0: begin
                m_ram[a] = m_work;
                m_y = m_y + 4'h1;
            end
            4'h1: m_y = m_ram[a];
            4'h2: m_work = m_ram[a];
            4'h3: begin
                t = m_work;
                m_work = m_ram[a];
                m_ram[a] = t;
            end
            4'h4: begin
                m_ram[a] = arg[3:0];
                m_y = m_y + 4'h1;
            end
            4'h5: m_x = {2'b00, arg[1:0]};
            4'h6: m_ram[a][arg[1:0]] = 1'b1;
            4'h7: m_ram[a][arg[1:0]] = 1'b0;
            4'ha: m_pb = arg[3:0];
            default: ;
        endcase
        // Jump kind judged before the page copy
        if (op == 4'h9) begin
            m_taken = m_flag;
            m_long = m_flag && (m_pb != m_pa);
        end
        if (taken) begin
            m_pa = m_pb;
            m_pc = arg;
        end else begin
            m_pc = seq(m_pc);
        end
        m_flag = (op == 4'h8) ? m_ram[a][arg[1:0]] : 1'b1;
        wr(`REG_INSTR, {20'h0, op, 2'b00, arg});
        ports();
    endtask : exec

    initial begin
        presetn = 1'b0;
        req = '0;
        rnd = 32'd48171;
        {m_work, m_x, m_y, m_pa, m_pb, m_pc} = '0;
        m_flag = 1'b1;
        m_taken = 1'b0;
        m_long = 1'b0;
        foreach (m_ram[i]) m_ram[i] = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state, then refused accesses leave it untouched
        ports();
        rd(`REG_FLAG, 32'h1);
        check_regs();
        apb(1'b0, 8'h1c, 32'h0, 1'b1, 32'h0);
        apb(1'b1, 8'h20, 32'h5, 1'b1, 32'h0);
        apb(1'b1, `REG_INSTR, 32'h0000_0b00, 1'b1, 32'h0);
        ports();
        // Store with word index at 15 wraps it to 0
        m_work = 4'h9;
        wr(`REG_WORK, 32'h9);
        set_index(4'h2, 4'hf);
        exec(4'h0, 6'h00);
        exec(4'h4, 6'h0c);
        set_index(4'h2, 4'hf);
        // Work differs from RAM so a one-sided swap shows up
        m_work = 4'h5;
        wr(`REG_WORK, 32'h5);
        exec(4'h3, 6'h00);
        check_regs();
        exec(4'h3, 6'h00);
        check_regs();
        for (int p = 0; p < 4; p++) begin
            exec(4'h5, 6'(p));
        end
        // Every bit: set, test, clear, test, then jump not taken
        for (int n = 0; n < 4; n++) begin
            exec(4'h6, 6'(n));
            exec(4'h8, 6'(n));
            exec(4'h7, 6'(n));
            exec(4'h8, 6'(n));
            exec(4'h9, 6'h2a);
            check_regs();
        end
        // Long jump after buffer load, then two short ones to 0x3f
        exec(4'ha, 6'h03);
        exec(4'h9, 6'h15);
        check_regs();
        exec(4'h9, 6'h3f);
        exec(4'h9, 6'h3f);
        // Random instruction mix with occasional direct loads
        for (int i = 0; i < 300; i++) begin
            rnd = xs(rnd);
            if (rnd[31:29] == 3'b000) begin
                m_ram[{m_x[1:0], m_y}] = rnd[11:8];
                wr(`REG_MEM, {28'h0, rnd[11:8]});
            end
            if (rnd[28:26] == 3'b000) begin
                set_index(rnd[19:16], rnd[15:12]);
            end
            exec(4'(rnd % 32'd11), rnd[25:20]);
            if (i % 16 == 0) begin
                check_regs();
            end
        end
        check_regs();
        report_and_stop();
    end

endmodule : tb
